// >>> inc/gcd_pkg.sv
// Constants, register map and sequencer states of the gated clock divider
package gcd_pkg;
    localparam int unsigned FACT_W = 8;
    localparam logic [FACT_W-1:0] FACT_MAX = 8'hff;
    localparam logic [FACT_W-1:0] FACT_ONE = 8'h01;
    localparam logic [FACT_W-1:0] FACT_ZERO = 8'h00;
    // Register byte offsets
    localparam logic [3:0] OFS_CONFIG = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    // Config fields
    localparam int unsigned CFG_PRESCALE_LSB = 0;
    localparam int unsigned CFG_DIVIDE_LSB = 8;
    localparam int unsigned CFG_REFDIS_BIT = 16;
    // Status fields
    localparam int unsigned STS_STATE_LSB = 0;
    localparam int unsigned STS_OSC_BIT = 8;
    localparam int unsigned STS_MAIN_EN_BIT = 9;
    localparam int unsigned STS_MAIN_OE_BIT = 10;
    localparam int unsigned STS_REF_OE_BIT = 11;
    localparam int unsigned STS_GATE_BIT = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        ST_INIT = 4'h0,
        ST_OSC_ON = 4'h1,
        ST_WAIT_GATE = 4'h2,
        ST_STAB = 4'h3,
        ST_LOAD = 4'h4,
        ST_REF_ON = 4'h5,
        ST_RUN = 4'h6,
        ST_PD_GATE = 4'h7,
        ST_PD_MAIN_Z = 4'h8,
        ST_PD_REF_Z = 4'h9,
        ST_OFF = 4'ha
    } gcd_state_t;
endpackage : gcd_pkg

// >>> core/gcd_top.sv
// Gated clock divider with power sequencer and AXI4-Lite configuration
// Contract
// - Gate low: hold main low, never truncate.
// - Gated off: oscillator runs, divider held reset.
// - Gate release: first edge within 1-2 periods.
// - Gate sampled on prescaled rising edges.
// - Missed setup delays action one prescaled cycle.
// - Late fall while low passes one pulse.
// - Divide-by-one passes one or two pulses.
// - Sleep low gates main, resets divider.
// - Main goes high impedance once low.
// - Then stop prescaler, reference glitchless Z.
// - Finally oscillator off, both outputs Z.
// - Wake: oscillator on, factors forced maximum.
// - Wait about 256 prescaled cycles.
// - Restore programmed factors before enabling outputs.
// - Reference first if enabled, main after.
// - Power-on: init, stabilize, load stored factors.
// - Gate never affects reference output; gate low at wake delays its enable.
// - Option permanently disables reference output.
// - Reference from prescaler, main from divider, or from the prescaler directly at divide-by-one.
// - Stabilization waits while gate held low.
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
module gcd_top #(
    parameter logic [7:0] PRESCALE_DEFAULT = 8'h01,
    parameter logic [7:0] DIVIDE_DEFAULT = 8'h02,
    parameter logic REF_DISABLE_DEFAULT = 1'b0,
    parameter int unsigned STAB_CYCLES = 256
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Asynchronous pins
    input wire logic gate_enable,
    input wire logic sleep_request_low,
    // Clock outputs with enables
    output logic main_clock_out,
    output logic main_clock_out_oe,
    output logic reference_clock_out,
    output logic reference_clock_out_oe
);
    localparam logic [15:0] STAB_LAST = 16'(STAB_CYCLES - 1);

    initial begin
        if (STAB_CYCLES < 1 || STAB_CYCLES > 65536) begin
            $error("STAB_CYCLES out of range");
        end
        if (PRESCALE_DEFAULT == gcd_pkg::FACT_ZERO) begin
            $error("Prescale factor must be nonzero");
        end
        if (DIVIDE_DEFAULT == gcd_pkg::FACT_ZERO) begin
            $error("Divide factor must be nonzero");
        end
    end

    function automatic logic [7:0] gcd_nz(input logic [7:0] v, input logic [7:0] old);
        gcd_nz = (v == gcd_pkg::FACT_ZERO) ? old : v;
    endfunction : gcd_nz

    // Last count of a factor; a count left above a newly loaded factor wraps at once,
    // so a factor swap never stalls a counter for a full 256-count lap
    function automatic logic gcd_at_end(input logic [7:0] cnt, input logic [7:0] fact);
        gcd_at_end = cnt >= fact - gcd_pkg::FACT_ONE;
    endfunction : gcd_at_end

    // Pin synchronisers
    logic gate_m_q;
    logic gate_s_q;
    logic sleep_m_q;
    logic sleep_s_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_m_q <= 1'b0;
            gate_s_q <= 1'b0;
            sleep_m_q <= 1'b1;
            sleep_s_q <= 1'b1;
        end else begin
            gate_m_q <= gate_enable;
            gate_s_q <= gate_m_q;
            sleep_m_q <= sleep_request_low;
            sleep_s_q <= sleep_m_q;
        end
    end

    // Configuration, standing in for the stored factory settings
    logic [7:0] cfg_pre_q;
    logic [7:0] cfg_div_q;
    logic cfg_refdis_q;

    // Sequencer state and the factors in force
    gcd_pkg::gcd_state_t st_q;
    gcd_pkg::gcd_state_t st_d;
    logic [7:0] m_act_q;
    logic [7:0] m_act_d;
    logic [7:0] n_act_q;
    logic [7:0] n_act_d;

    // Clock and pin enables
    logic osc_en_q;
    logic osc_en_d;
    logic mclk_en_q;
    logic mclk_en_d;
    logic main_oe_q;
    logic main_oe_d;
    logic ref_oe_q;
    logic ref_oe_d;
    logic [15:0] stab_q;
    logic [15:0] stab_d;

    // Main gating
    logic en_q;
    logic gate_smp_q;

    // AXI4-Lite slave: one write and one read outstanding
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire rd_go = s_axi_arvalid && !s_axi_rvalid;
    wire wr_cfg = s_axi_awaddr == gcd_pkg::OFS_CONFIG;
    wire wr_hit = wr_cfg || s_axi_awaddr == gcd_pkg::OFS_STATUS;
    wire rd_cfg = s_axi_araddr == gcd_pkg::OFS_CONFIG;
    wire rd_sts = s_axi_araddr == gcd_pkg::OFS_STATUS;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;

    wire [31:0] cfg_word = {15'h0000, cfg_refdis_q, cfg_div_q, cfg_pre_q};
    wire [31:0] sts_word = {19'h00000, gate_smp_q, ref_oe_q, main_oe_q, en_q, osc_en_q,
        4'h0, st_q};
    wire [31:0] rd_word = rd_cfg ? cfg_word : (rd_sts ? sts_word : 32'h00000000);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_pre_q <= PRESCALE_DEFAULT;
            cfg_div_q <= DIVIDE_DEFAULT;
            cfg_refdis_q <= REF_DISABLE_DEFAULT;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gcd_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= gcd_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? gcd_pkg::RESP_OKAY : gcd_pkg::RESP_SLVERR;
                // Zero factors are refused, the previous value stays
                if (wr_cfg && s_axi_wstrb[0]) begin
                    cfg_pre_q <= gcd_nz(s_axi_wdata[gcd_pkg::CFG_PRESCALE_LSB +: 8], cfg_pre_q);
                end
                if (wr_cfg && s_axi_wstrb[1]) begin
                    cfg_div_q <= gcd_nz(s_axi_wdata[gcd_pkg::CFG_DIVIDE_LSB +: 8], cfg_div_q);
                end
                if (wr_cfg && s_axi_wstrb[2]) begin
                    cfg_refdis_q <= s_axi_wdata[gcd_pkg::CFG_REFDIS_BIT];
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (rd_cfg || rd_sts) ? gcd_pkg::RESP_OKAY : gcd_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Prescaler: the prescaled clock toggles every m_act master cycles
    logic [7:0] pcnt_q;
    logic prs_q;
    wire pre_run = osc_en_q && mclk_en_q;
    wire pre_wrap = pre_run && gcd_at_end(pcnt_q, m_act_q);
    wire prs_rise = pre_wrap && !prs_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pcnt_q <= gcd_pkg::FACT_ZERO;
            prs_q <= 1'b0;
        end else if (pre_run) begin
            pcnt_q <= pre_wrap ? gcd_pkg::FACT_ZERO : pcnt_q + gcd_pkg::FACT_ONE;
            prs_q <= prs_q ^ pre_wrap;
        end
    end

    // Divider, held in reset while the main output is gated off
    logic [7:0] dcnt_q;
    logic div_q;
    // High for the first half of the count, rounded up, so odd factors lean high
    wire [7:0] dcnt_nx = gcd_at_end(dcnt_q, n_act_q) ? gcd_pkg::FACT_ZERO
        : dcnt_q + gcd_pkg::FACT_ONE;
    wire [7:0] n_high = 8'((9'(n_act_q) + 9'h001) >> 1);
    wire div_one = n_act_q == gcd_pkg::FACT_ONE;
    wire raw_main = div_one ? prs_q : div_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dcnt_q <= gcd_pkg::FACT_ZERO;
            div_q <= 1'b0;
        end else if (!en_q) begin
            dcnt_q <= gcd_pkg::FACT_ZERO;
            div_q <= 1'b0;
        end else if (prs_rise) begin
            dcnt_q <= dcnt_nx;
            div_q <= dcnt_q < n_high;
        end
    end

    // Gate sampling and enable; the extra-pulse cases follow from the sample edge
    wire main_allow = st_q == gcd_pkg::ST_RUN;
    wire gate_eff = gate_smp_q && main_allow;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_smp_q <= 1'b0;
            en_q <= 1'b0;
            main_clock_out <= 1'b0;
        end else begin
            if (prs_rise) begin
                gate_smp_q <= gate_s_q;
            end
            if (!gate_eff && !raw_main) begin
                en_q <= 1'b0;
            end else if (gate_eff && prs_rise) begin
                en_q <= 1'b1;
            end
            main_clock_out <= raw_main && en_q;
        end
    end

    assign reference_clock_out = prs_q;
    assign main_clock_out_oe = main_oe_q;
    assign reference_clock_out_oe = ref_oe_q;

    // Factors swap in the low phase, so no short reference pulse appears
    wire load_ok = !prs_q;
    // Prescaler may stop when its next value is low: a falling wrap or a quiet low phase.
    // Needed for a factor of one, where every cycle wraps and a quiet phase never comes.
    wire ref_stop_ok = prs_q == pre_wrap;

    // Power sequencer
    always_comb begin
        st_d = st_q;
        m_act_d = m_act_q;
        n_act_d = n_act_q;
        osc_en_d = osc_en_q;
        mclk_en_d = mclk_en_q;
        main_oe_d = main_oe_q;
        ref_oe_d = ref_oe_q;
        stab_d = stab_q;
        case (st_q)
            gcd_pkg::ST_INIT: begin
                st_d = gcd_pkg::ST_OSC_ON;
            end
            gcd_pkg::ST_OSC_ON: begin
                osc_en_d = 1'b1;
                mclk_en_d = 1'b1;
                m_act_d = gcd_pkg::FACT_MAX;
                n_act_d = gcd_pkg::FACT_MAX;
                st_d = gcd_pkg::ST_WAIT_GATE;
            end
            gcd_pkg::ST_WAIT_GATE: begin
                stab_d = 16'h0000;
                if (gate_s_q) begin
                    st_d = gcd_pkg::ST_STAB;
                end
            end
            gcd_pkg::ST_STAB: begin
                if (prs_rise) begin
                    stab_d = stab_q + 16'h0001;
                    if (stab_q == STAB_LAST) begin
                        st_d = gcd_pkg::ST_LOAD;
                    end
                end
            end
            gcd_pkg::ST_LOAD: begin
                // A count above the new factor wraps at once
                if (load_ok) begin
                    m_act_d = cfg_pre_q;
                    n_act_d = cfg_div_q;
                    st_d = gcd_pkg::ST_REF_ON;
                end
            end
            gcd_pkg::ST_REF_ON: begin
                ref_oe_d = !cfg_refdis_q;
                st_d = gcd_pkg::ST_RUN;
            end
            gcd_pkg::ST_RUN: begin
                main_oe_d = 1'b1;
                if (!sleep_s_q) begin
                    st_d = gcd_pkg::ST_PD_GATE;
                end
            end
            gcd_pkg::ST_PD_GATE: begin
                if (!en_q && !main_clock_out) begin
                    st_d = gcd_pkg::ST_PD_MAIN_Z;
                end
            end
            gcd_pkg::ST_PD_MAIN_Z: begin
                main_oe_d = 1'b0;
                st_d = gcd_pkg::ST_PD_REF_Z;
            end
            gcd_pkg::ST_PD_REF_Z: begin
                // Stop only where the prescaled clock ends low, so the last pulse is whole
                if (ref_stop_ok) begin
                    mclk_en_d = 1'b0;
                    ref_oe_d = 1'b0;
                    st_d = gcd_pkg::ST_OFF;
                end
            end
            gcd_pkg::ST_OFF: begin
                osc_en_d = 1'b0;
                if (sleep_s_q && !osc_en_q) begin
                    st_d = gcd_pkg::ST_OSC_ON;
                end
            end
            default: begin
                st_d = gcd_pkg::ST_INIT;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= gcd_pkg::ST_INIT;
            m_act_q <= gcd_pkg::FACT_MAX;
            n_act_q <= gcd_pkg::FACT_MAX;
            osc_en_q <= 1'b0;
            mclk_en_q <= 1'b0;
            main_oe_q <= 1'b0;
            ref_oe_q <= 1'b0;
            stab_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            m_act_q <= m_act_d;
            n_act_q <= n_act_d;
            osc_en_q <= osc_en_d;
            mclk_en_q <= mclk_en_d;
            main_oe_q <= main_oe_d;
            ref_oe_q <= ref_oe_d;
            stab_q <= stab_d;
        end
    end
endmodule : gcd_top

// >>> tb/gcd_top_assertions.sv
// Checker of pin sequencing for the gated clock divider
module gcd_checker #(
    parameter logic [7:0] PRESCALE_DEFAULT = 8'h01,
    parameter int unsigned STAB_CYCLES = 256
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control pins
    input wire logic gate_enable,
    input wire logic sleep_request_low,
    // Clock pins
    input wire logic main_clock_out,
    input wire logic main_clock_out_oe,
    input wire logic reference_clock_out,
    input wire logic reference_clock_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // First prescaled rise may come early, so one period of slack
    localparam int STAB_LEN = (STAB_CYCLES - 1) * 510;
    logic [5:0] gl_q;
    logic [5:0] sl_q;
    logic [17:0] wk_q;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        gl_q <= (!aresetn || gate_enable) ? 6'h00 : gl_q + {5'h00, gl_q != 6'h3f};
        sl_q <= (!aresetn || sleep_request_low) ? 6'h00 : sl_q + {5'h00, sl_q != 6'h3f};
        wk_q <= (!aresetn || !sleep_request_low) ? 18'h0 : wk_q + {17'h0, wk_q != 18'h3ffff};
    end
    sequence s_sleep_start;
        $fell(sleep_request_low) && main_clock_out_oe;
    endsequence
    sequence s_gate_release;
        $rose(gate_enable) && main_clock_out_oe;
    endsequence
    property p_ref_toggle;
        reference_clock_out_oe && $past(reference_clock_out_oe) && PRESCALE_DEFAULT == 8'h01
            |-> reference_clock_out != $past(reference_clock_out);
    endproperty
    property p_gate_off;
        gl_q >= 6'h18 |-> !main_clock_out;
    endproperty
    property p_gate_release;
        s_gate_release |-> ##[1:16] main_clock_out;
    endproperty
    property p_sleep_main_off;
        s_sleep_start |-> ##[1:40] !main_clock_out_oe;
    endproperty
    property p_main_z_low;
        $fell(main_clock_out_oe) |-> !$past(main_clock_out);
    endproperty
    property p_ref_z_after;
        $fell(reference_clock_out_oe) |-> !main_clock_out_oe && !reference_clock_out;
    endproperty
    property p_deep_off;
        sl_q >= 6'h18 |-> !main_clock_out_oe && !reference_clock_out_oe;
    endproperty
    property p_stab_wait;
        $rose(main_clock_out_oe) |-> int'(wk_q) >= STAB_LEN;
    endproperty
    property p_ref_first;
        $rose(reference_clock_out_oe) |-> !main_clock_out_oe;
    endproperty
    a_ref_toggle: assert property (p_ref_toggle)
        else $error("reference stalled");
    a_gate_off: assert property (p_gate_off)
        else $error("main runs while gated");
    a_gate_release: assert property (p_gate_release)
        else $error("main late after gate");
    a_sleep_main_off: assert property (p_sleep_main_off)
        else $error("main not stopped by sleep");
    a_main_z_low: assert property (p_main_z_low)
        else $error("main released high");
    a_ref_z_after: assert property (p_ref_z_after)
        else $error("reference released early");
    a_deep_off: assert property (p_deep_off)
        else $error("outputs driven in sleep");
    a_stab_wait: assert property (p_stab_wait)
        else $error("main enabled too soon");
    a_ref_first: assert property (p_ref_first)
        else $error("reference after main");
endmodule : gcd_checker

bind gcd_top gcd_checker #(.PRESCALE_DEFAULT(PRESCALE_DEFAULT), .STAB_CYCLES(STAB_CYCLES)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .gate_enable(gate_enable),
    .sleep_request_low(sleep_request_low), .main_clock_out(main_clock_out),
    .main_clock_out_oe(main_clock_out_oe), .reference_clock_out(reference_clock_out),
    .reference_clock_out_oe(reference_clock_out_oe));

// >>> tb/gcd_sys_model.sv
// Behavioural model of the system logic on the pin side
module gcd_sys_model (
    // Clock
    input wire logic aclk,
    // Bench requests
    input wire logic gate_req,
    input wire logic sleep_req,
    // Control pins
    output logic gate_enable,
    output logic sleep_request_low,
    // Main clock pin
    input wire logic main_clock_out,
    input wire logic main_clock_out_oe,
    output logic main_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic main_last = 1'b0;
    initial begin
        gate_enable = 1'b1;
        sleep_request_low = 1'b1;
    end
    // Gate held high through wake unless a scenario lowers it
    always @(posedge aclk) begin
        gate_enable <= gate_req;
        sleep_request_low <= !sleep_req;
        main_last <= main_pin;
    end
    // Released line has no pull, so it wanders every cycle
    assign main_pin = main_clock_out_oe ? main_clock_out : ~main_last;
endmodule : gcd_sys_model

// >>> tb/gcd_top_tb.sv
// Self-checking bench for the gated clock divider
module gcd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned STAB = 2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic gate_req = 1'b1;
    logic sleep_req = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, gate_en, sleep_low;
    logic main_out, main_oe, ref_out, ref_oe, main_pin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_errors = 0;
    int n_tests = 0;
    int seed = 62;
    always #5 aclk = ~aclk;
    gcd_top #(.PRESCALE_DEFAULT(8'h01), .DIVIDE_DEFAULT(8'h02), .REF_DISABLE_DEFAULT(1'b0),
        .STAB_CYCLES(STAB)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .gate_enable(gate_en), .sleep_request_low(sleep_low), .main_clock_out(main_out),
        .main_clock_out_oe(main_oe), .reference_clock_out(ref_out),
        .reference_clock_out_oe(ref_oe));
    gcd_sys_model u_sys (.aclk(aclk), .gate_req(gate_req), .sleep_req(sleep_req),
        .gate_enable(gate_en), .sleep_request_low(sleep_low), .main_clock_out(main_out),
        .main_clock_out_oe(main_oe), .main_pin(main_pin));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic stop_test();
        if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    function automatic logic [31:0] cfg(input logic [7:0] n, input logic dis);
        return {15'h0, dis, n, 8'h01};
    endfunction : cfg
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge aclk);
        while (!awready) @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(posedge aclk);
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
        check("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (!arready) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (!rvalid) @(posedge aclk);
        rready <= 1'b0;
        check("rdata", ed, rdata);
        check("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : axi_rd
    task automatic period(input int exp);
        int n;
        n = 0;
        while (main_pin !== 1'b0) @(posedge aclk);
        while (main_pin !== 1'b1) @(posedge aclk);
        while (main_pin !== 1'b0) @(posedge aclk) n++;
        while (main_pin !== 1'b1) @(posedge aclk) n++;
        check("main period", exp, n);
    endtask : period
    task automatic power_cycle(input logic gate_lo, input logic exp_ref);
        @(posedge aclk);
        sleep_req <= 1'b1;
        @(posedge aclk);
        while (ref_oe !== 1'b0) @(posedge aclk);
        check("main_oe", 32'h0, {31'h0, main_oe});
        gate_req <= !gate_lo;
        repeat (24) @(posedge aclk);
        sleep_req <= 1'b0;
        if (gate_lo) begin
            repeat (1500) @(posedge aclk);
            check("stalled oe", 32'h0, {30'h0, main_oe, ref_oe});
            gate_req <= 1'b1;
        end
        while (main_oe !== 1'b1) @(posedge aclk);
        check("ref_oe", {31'h0, exp_ref}, {31'h0, ref_oe});
    endtask : power_cycle
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        while (main_oe !== 1'b1) @(posedge aclk);
        check("ref_oe", 32'h1, {31'h0, ref_oe});
        period(4);
        axi_rd(4'h0, cfg(8'h02, 1'b0), gcd_pkg::RESP_OKAY);
        axi_rd(4'h8, 32'h0, gcd_pkg::RESP_SLVERR);
        axi_wr(4'h4, 32'hffff_ffff, gcd_pkg::RESP_OKAY);
        axi_wr(4'h0, 32'h0, gcd_pkg::RESP_OKAY);
        axi_rd(4'h0, cfg(8'h02, 1'b0), gcd_pkg::RESP_OKAY);
        for (int d = 1; d <= 4; d++) begin
            axi_wr(4'h0, cfg(8'(d), 1'b0), gcd_pkg::RESP_OKAY);
            power_cycle(1'b0, 1'b1);
            period(2 * d);
            repeat ($random(seed) & 7) @(posedge aclk);
            gate_req <= 1'b0;
            repeat (30 + ($random(seed) & 15)) @(posedge aclk);
            check("gated main", 32'h0, {31'h0, main_pin});
            gate_req <= 1'b1;
            repeat (20) @(posedge aclk);
            period(2 * d);
        end
        axi_wr(4'h0, cfg(8'h02, 1'b1), gcd_pkg::RESP_OKAY);
        power_cycle(1'b1, 1'b0);
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge aclk);
        n_errors++;
        stop_test();
    end
endmodule : gcd_top_tb
